// File: bench/spi_master_model.sv
// Outside SPI master that faces the block while it runs in slave mode.
module spi_master_model (
  input  wire logic i_clock,
  output logic      o_sck,
  output logic      o_scs_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // The clock idles high and stands still between frames.
  // The select line also idles high, so the slave stays deselected.
  initial
  begin
    o_sck   = 1'b1;
    o_scs_n = 1'b1;
  end

  // The master owns the serial clock; each phase lasts four system cycles.
  // Four cycles clears the two-cycle delay of the two-stage synchroniser.
  // A frame with fewer than eight rising edges raises select in mid-byte.
  task automatic frame(input int n_edges);
    @(posedge i_clock);
    o_scs_n <= 1'b0;
    repeat (4) @(posedge i_clock);
    repeat (n_edges)
    begin
      o_sck <= 1'b0;
      repeat (4) @(posedge i_clock);
      o_sck <= 1'b1;
      repeat (4) @(posedge i_clock);
    end
    repeat (8) @(posedge i_clock);
    o_scs_n <= 1'b1;
    repeat (8) @(posedge i_clock);
  endtask : frame
endmodule : spi_master_model

// File: bench/tb.sv
`include "serial_mode_consts.svh"

module tb
  import serial_mode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       i_clock, i_reset_n, i_wr, i_rd, i_sub_clock, i_timer_match;
  logic       i_sck_in, i_scs_n_in, o_sck_out, o_sck_oe, o_sdo_oe, o_twi_active, o_irq;
  logic [3:0] i_addr;
  logic [1:0] o_debounce_sel, o_tw_ctl;
  byte_t      i_wdata, o_rdata;
  tw_flags_s  i_tw_set;
  int         n_mismatch, total_checks, tick, m, p_meas;
  int         per[5] = '{4, 16, 64, 20, 12};

  serial_mode_enable_ctrl serial_mode_enable_ctrl_i (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sck_in(i_sck_in),
    .i_scs_n_in(i_scs_n_in), .i_sub_clock(i_sub_clock), .i_timer_match(i_timer_match),
    .i_tw_set(i_tw_set), .o_sck_out(o_sck_out), .o_sck_oe(o_sck_oe), .o_sdo_oe(o_sdo_oe),
    .o_twi_active(o_twi_active), .o_debounce_sel(o_debounce_sel), .o_tw_ctl(o_tw_ctl),
    .o_irq(o_irq)
  );

  spi_master_model spi_master_model_i (
    .i_clock(i_clock), .o_sck(i_sck_in), .o_scs_n(i_scs_n_in)
  );

  // System clock, 25 ns period.
  initial
  begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end

  // Subsidiary clock of 20 cycles and a timer match pulse every 6 cycles.
  always @(posedge i_clock)
  begin
    tick          <= tick + 1;
    i_sub_clock   <= (tick % 20) < 10;
    i_timer_match <= (tick % 6) == 0;
  end

  task final_report;
    if (n_mismatch == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  task chk(input byte_t got, input byte_t exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task chk_n(input int got, input int exp);
    total_checks++;
    if (got != exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk_n

  // The extra 1 ns lets the register update land before anyone samples.
  task wr(input logic [3:0] a, input byte_t d);
    @(posedge i_clock);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clock);
    i_wr    <= 1'b0;
    #1;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample there.
  task rchk(input logic [3:0] a, input byte_t exp);
    @(posedge i_clock);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clock);
    i_rd   <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask : rchk

  // Cycles between two rising edges of the master clock, or -1 if none.
  task period(output int p);
    logic prev;
    int   n, first;
    prev  = o_sck_out;
    first = -1;
    p     = -1;
    for (n = 0; n < 400 && p < 0; n++)
    begin
      @(posedge i_clock);
      #1;
      if (o_sck_out && !prev)
      begin
        if (first < 0)
          first = n;
        else
          p = n - first;
      end
      prev = o_sck_out;
    end
  endtask : period

  // A hang is cut short long after the tests should have finished.
  initial
  begin
    repeat (20000) @(posedge i_clock);
    n_mismatch++;
    final_report;
  end

  // Main sequence.
  initial
  begin
    {i_reset_n, i_wr, i_rd, i_addr, i_wdata, i_tw_set} = '0;
    {n_mismatch, total_checks} = '0;
    repeat (10) @(posedge i_clock);
    i_reset_n <= 1'b1;
    rchk(`OFS_CTRL, 8'hE0);
    rchk(`OFS_SPI_CTL, 8'h00);
    rchk(`OFS_TW_STAT, 8'h01);
    rchk(4'hA, 8'h00);
    wr(`OFS_CTRL, 8'h1C);
    rchk(`OFS_CTRL, 8'h0C);
    chk({6'h00, o_debounce_sel}, 8'h00);
    // Every master clock source, with debounce set to show it stays inert.
    for (m = 0; m < 5; m++)
    begin
      wr(`OFS_CTRL, byte_t'(m << 5));
      wr(`OFS_CTRL, byte_t'((m << 5) | 8'h0E));
      chk({o_sck_oe, o_debounce_sel, o_sdo_oe, 4'h0}, 8'h90);
      period(p_meas);
      period(p_meas);
      chk_n(p_meas, per[m]);
      wr(`OFS_CTRL, byte_t'(m << 5));
      chk({6'h00, o_sck_oe, o_sdo_oe}, 8'h00);
    end
    // Slave mode: a whole byte, then a byte cut short by the select line.
    wr(`OFS_SPI_CTL, 8'h04);
    wr(`OFS_CTRL, 8'hA0);
    wr(`OFS_CTRL, 8'hA2);
    rchk(`OFS_SPI_CTL, 8'h04);
    chk({6'h00, o_sck_oe, o_sdo_oe}, 8'h00);
    wr(`OFS_IRQ_MASK, 8'h03);
    spi_master_model_i.frame(8);
    rchk(`OFS_SPI_CTL, 8'h05);
    rchk(`OFS_IRQ_STAT, 8'h01);
    chk({7'h00, o_irq}, 8'h01);
    wr(`OFS_IRQ_STAT, 8'h01);
    wr(`OFS_SPI_CTL, 8'h04);
    chk({7'h00, o_irq}, 8'h00);
    spi_master_model_i.frame(3);
    rchk(`OFS_CTRL, 8'hA3);
    rchk(`OFS_IRQ_STAT, 8'h03);
    rchk(`OFS_SPI_CTL, 8'h05);
    // Two-wire: control bits survive an enable rise, flags return to default.
    wr(`OFS_CTRL, 8'hA0);
    wr(`OFS_CTRL, 8'hCC);
    chk({7'h00, o_twi_active}, 8'h00);
    wr(`OFS_TW_CTL, 8'h03);
    @(posedge i_clock);
    i_tw_set <= 5'h1E;
    @(posedge i_clock);
    i_tw_set <= 5'h00;
    rchk(`OFS_TW_STAT, 8'h1F);
    wr(`OFS_CTRL, 8'hCE);
    rchk(`OFS_TW_STAT, 8'h01);
    rchk(`OFS_TW_CTL, 8'h03);
    chk({3'h0, o_twi_active, o_debounce_sel, o_tw_ctl}, 8'h1F);
    // The unused mode drives nothing even when enabled.
    wr(`OFS_CTRL, 8'hCC);
    wr(`OFS_CTRL, 8'hE2);
    chk({6'h00, o_sck_oe, o_twi_active}, 8'h00);
    final_report;
  end
endmodule : tb

// File: hw/clk_divider.sv
module clk_divider #(
  parameter int CW = 6
) (
  input  wire logic          i_clock,
  input  wire logic          i_reset_n,
  input  wire logic          i_enable,
  input  wire logic [CW-1:0] i_half,
  output logic               o_level
);
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          lvl_reg;
  logic          lvl_next;

  // The level flips every i_half cycles; stopped, it rests low from count zero.
  always_comb
  begin
    cnt_next = cnt_reg;
    lvl_next = lvl_reg;
    if (!i_enable)
    begin
      cnt_next = '0;
      lvl_next = 1'b0;
    end
    else if (cnt_reg >= i_half - CW'(1))
    begin
      cnt_next = '0;
      lvl_next = ~lvl_reg;
    end
    else
    begin
      cnt_next = cnt_reg + CW'(1);
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cnt_reg <= '0;
      lvl_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      lvl_reg <= lvl_next;
    end
  end
  assign o_level = lvl_reg;
endmodule : clk_divider

// File: hw/serial_mode_consts.svh
`ifndef SERIAL_MODE_CONSTS_SVH
`define SERIAL_MODE_CONSTS_SVH
// Contract
// - Mode 000, 001 and 010 make the block an SPI master clocking at the system clock over 4, 16 or 64.
// - Mode 011 makes it an SPI master whose serial clock is the subsidiary clock itself.
// - Mode 100 makes it an SPI master whose serial clock is half the timer-zero match rate.
// - Mode 110 selects two-wire slave operation and 111 has no interface function.
// - Bit 4 of the mode and enable register is not implemented and always reads zero.
// - The debounce selection acts only in two-wire mode and has no effect in SPI modes.
// - With the enable bit at 0 all serial lines are released and the block rests; 1 enables it.
// - In SPI configuration a rising enable leaves the SPI control register unchanged.
// - In two-wire configuration a rising enable leaves the direction and ack-to-send bits unchanged.
// - In two-wire configuration a rising enable returns the five two-wire flags to their defaults.
// - An SPI slave whose select rises before the byte ends sets slave-incomplete with transfer-complete.

// Register offsets on the plain register port.
`define OFS_CTRL       4'h0
`define OFS_SPI_CTL    4'h1
`define OFS_TW_CTL     4'h2
`define OFS_TW_STAT    4'h3
`define OFS_IRQ_STAT   4'h4
`define OFS_IRQ_MASK   4'h5

// Field positions.
`define CTRL_MODE_HI   7
`define CTRL_MODE_LO   5
`define CTRL_DEB_HI    3
`define CTRL_DEB_LO    2
`define CTRL_EN        1
`define CTRL_ICF       0
`define SPI_CKPOL      5
`define SPI_CKEG       4
`define SPI_SELECT_PIN_ENABLE       2
`define SPI_TRF        0
`define IRQ_TRF        0
`define IRQ_ICF        1
`define IRQ_BYTE       2

// Reset values and defaults.
`define CTRL_RST       8'hE0
`define SPI_CTL_RST    8'h00
`define TW_CTL_RST     2'h0
`define TW_FLAGS_DEF   5'h01

// Mode codes.
`define MODE_DIV4      3'h0
`define MODE_DIV16     3'h1
`define MODE_DIV64     3'h2
`define MODE_SUB       3'h3
`define MODE_TMR       3'h4
`define MODE_SLAVE     3'h5
`define MODE_TWI       3'h6

// Half periods of the divided master clocks, and the bit count at the last bit of a transfer.
`define HALF_DIV4      6'h02
`define HALF_DIV16     6'h08
`define HALF_DIV64     6'h20
`define SPI_LAST_BIT   3'h7
`endif

// File: hw/serial_mode_enable_ctrl.sv
// Design decisions made here: the strobed register port and the placing of the registers.
`include "serial_mode_consts.svh"

module serial_mode_enable_ctrl
  import serial_mode_pkg::*;
(
  input  wire logic      i_clock,
  input  wire logic      i_reset_n,
  input  wire logic [3:0] i_addr,
  input  wire byte_t     i_wdata,
  input  wire logic      i_wr,
  input  wire logic      i_rd,
  output byte_t          o_rdata,
  input  wire logic      i_sck_in,
  input  wire logic      i_scs_n_in,
  input  wire logic      i_sub_clock,
  input  wire logic      i_timer_match,
  input  wire tw_flags_s i_tw_set,
  output logic           o_sck_out,
  output logic           o_sck_oe,
  output logic           o_sdo_oe,
  output logic           o_twi_active,
  output logic [1:0]     o_debounce_sel,
  output logic [1:0]     o_tw_ctl,
  output logic           o_irq
);
  logic [2:0]   mode_reg, mode_next;
  logic [1:0]   deb_reg, deb_next;
  logic         en_reg, en_next;
  logic         icf_reg, icf_next;
  logic         en_prev_reg;
  byte_t        spi_reg, spi_next;
  logic [1:0]   twc_reg, twc_next;
  tw_flags_s    twf_reg, twf_next;
  logic [2:0]   ist_reg, ist_next;
  logic [2:0]   imask_reg, imask_next;
  byte_t        rdata_reg, rdata_next;
  logic         en_rise;
  logic         is_master;
  logic         sck_s, scs_n_s, sub_s, tmr_s;
  logic         sck_prev_reg, scs_prev_reg, tmr_prev_reg;
  slave_state_e st_reg, st_next;
  logic [2:0]   cnt_reg, cnt_next;
  slave_evt_s   evt_reg, evt_next;
  logic         slave_on, slave_sel, act_edge;
  logic         tmr_half_reg, tmr_half_next;
  logic         div_en, div_level;
  logic [5:0]   div_half;
  logic         sck_out_reg, sck_out_next;

  // Pin inputs from the far side cross into the system clock here.
  sync2 #(.W(4)) u_sync (
    .i_clock   (i_clock),
    .i_reset_n (i_reset_n),
    .i_d       ({i_sck_in, i_scs_n_in, i_sub_clock, i_timer_match}),
    .o_q       ({sck_s, scs_n_s, sub_s, tmr_s})
  );

  // Modes 000 to 100 are all master modes; slave mode drives no clock.
  assign is_master = en_reg && (mode_reg <= `MODE_TMR);
  assign en_rise   = en_reg && !en_prev_reg;

  // Register file: software writes first, hardware sets after, so a set beats a clear.
  always_comb
  begin
    mode_next  = mode_reg;
    deb_next   = deb_reg;
    en_next    = en_reg;
    icf_next   = icf_reg;
    spi_next   = spi_reg;
    twc_next   = twc_reg;
    twf_next   = twf_reg;
    ist_next   = ist_reg;
    imask_next = imask_reg;
    rdata_next = 8'h00;
    if (i_wr)
    begin
      case (i_addr)
        `OFS_CTRL:
        begin
          mode_next = i_wdata[`CTRL_MODE_HI:`CTRL_MODE_LO];
          deb_next  = i_wdata[`CTRL_DEB_HI:`CTRL_DEB_LO];
          en_next   = i_wdata[`CTRL_EN];
          icf_next  = i_wdata[`CTRL_ICF];
        end
        `OFS_SPI_CTL:  spi_next   = i_wdata;
        `OFS_TW_CTL:   twc_next   = i_wdata[1:0];
        `OFS_TW_STAT:  twf_next   = twf_reg & ~tw_flags_s'(i_wdata[4:0]);
        `OFS_IRQ_STAT: ist_next   = ist_reg & ~i_wdata[2:0];
        `OFS_IRQ_MASK: imask_next = i_wdata[2:0];
        default:       ;
      endcase
    end
    // Slave byte end and early select release both raise transfer-complete.
    if (evt_reg.done || evt_reg.incomplete)
    begin
      spi_next[`SPI_TRF]  = 1'b1;
      ist_next[`IRQ_TRF]  = 1'b1;
    end
    if (evt_reg.incomplete)
    begin
      icf_next            = 1'b1;
      ist_next[`IRQ_ICF]  = 1'b1;
    end
    twf_next = twf_next | i_tw_set;
    if (i_tw_set.byte_done)
    begin
      ist_next[`IRQ_BYTE] = 1'b1;
    end
    // The engine is idle at the moment of enabling, so forcing defaults wins here.
    if (en_rise && mode_reg == `MODE_TWI)
    begin
      twf_next = tw_flags_s'(`TW_FLAGS_DEF);
    end
    // The SPI and two-wire control bits are deliberately left alone on enable.
    if (i_rd)
    begin
      case (i_addr)
        `OFS_CTRL:     rdata_next = {mode_reg, 1'b0, deb_reg, en_reg, icf_reg};
        `OFS_SPI_CTL:  rdata_next = spi_reg;
        `OFS_TW_CTL:   rdata_next = {6'h00, twc_reg};
        `OFS_TW_STAT:  rdata_next = {3'h0, twf_reg};
        `OFS_IRQ_STAT: rdata_next = {5'h00, ist_reg};
        `OFS_IRQ_MASK: rdata_next = {5'h00, imask_reg};
        default:       rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      mode_reg    <= 3'(`CTRL_RST >> `CTRL_MODE_LO);
      deb_reg     <= 2'h0;
      en_reg      <= 1'b0;
      icf_reg     <= 1'b0;
      en_prev_reg <= 1'b0;
      spi_reg     <= `SPI_CTL_RST;
      twc_reg     <= `TW_CTL_RST;
      twf_reg     <= tw_flags_s'(`TW_FLAGS_DEF);
      ist_reg     <= 3'h0;
      imask_reg   <= 3'h0;
      rdata_reg   <= 8'h00;
    end
    else
    begin
      mode_reg    <= mode_next;
      deb_reg     <= deb_next;
      en_reg      <= en_next;
      icf_reg     <= icf_next;
      en_prev_reg <= en_reg;
      spi_reg     <= spi_next;
      twc_reg     <= twc_next;
      twf_reg     <= twf_next;
      ist_reg     <= ist_next;
      imask_reg   <= imask_next;
      rdata_reg   <= rdata_next;
    end
  end

  // Slave byte tracking; the active edge is rising when polarity and edge bits agree.
  assign slave_on  = en_reg && mode_reg == `MODE_SLAVE;
  assign slave_sel = spi_reg[`SPI_SELECT_PIN_ENABLE] ? !scs_n_s : 1'b1;
  assign act_edge  = (sck_s != sck_prev_reg) &&
                     (sck_s == (spi_reg[`SPI_CKPOL] == spi_reg[`SPI_CKEG]));

  always_comb
  begin
    st_next  = st_reg;
    cnt_next = cnt_reg;
    evt_next = '0;
    if (!slave_on)
    begin
      st_next  = ST_IDLE;
      cnt_next = 3'h0;
    end
    else
    begin
      case (st_reg)
        ST_IDLE:
        begin
          if (slave_sel && act_edge)
          begin
            st_next  = ST_SHIFT;
            cnt_next = 3'h1;
          end
        end
        ST_SHIFT:
        begin
          if (spi_reg[`SPI_SELECT_PIN_ENABLE] && scs_n_s && !scs_prev_reg)
          begin
            evt_next.incomplete = 1'b1;
            st_next             = ST_IDLE;
            cnt_next            = 3'h0;
          end
          else if (slave_sel && act_edge)
          begin
            if (cnt_reg == `SPI_LAST_BIT)
            begin
              evt_next.done = 1'b1;
              st_next       = ST_IDLE;
              cnt_next      = 3'h0;
            end
            else
            begin
              cnt_next = cnt_reg + 3'h1;
            end
          end
        end
        default:
        begin
          st_next  = ST_IDLE;
          cnt_next = 3'h0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      st_reg       <= ST_IDLE;
      cnt_reg      <= 3'h0;
      evt_reg      <= '0;
      sck_prev_reg <= 1'b0;
      scs_prev_reg <= 1'b0;
    end
    else
    begin
      st_reg       <= st_next;
      cnt_reg      <= cnt_next;
      evt_reg      <= evt_next;
      sck_prev_reg <= sck_s;
      scs_prev_reg <= scs_n_s;
    end
  end

  // Master clock sources. The divider only runs in the three divided modes.
  assign div_en   = en_reg && (mode_reg <= `MODE_DIV64);
  assign div_half = (mode_reg == `MODE_DIV4)  ? `HALF_DIV4 :
                    (mode_reg == `MODE_DIV16) ? `HALF_DIV16 : `HALF_DIV64;

  clk_divider #(.CW(6)) u_div (
    .i_clock   (i_clock),
    .i_reset_n (i_reset_n),
    .i_enable  (div_en),
    .i_half    (div_half),
    .o_level   (div_level)
  );

  // Each timer match flips the level, which halves the match rate.
  always_comb
  begin
    tmr_half_next = tmr_half_reg;
    if (!(en_reg && mode_reg == `MODE_TMR))
    begin
      tmr_half_next = 1'b0;
    end
    else if (tmr_s && !tmr_prev_reg)
    begin
      tmr_half_next = ~tmr_half_reg;
    end
    case (mode_reg)
      `MODE_DIV4, `MODE_DIV16, `MODE_DIV64: sck_out_next = div_level;
      `MODE_SUB:                            sck_out_next = sub_s;
      `MODE_TMR:                            sck_out_next = tmr_half_reg;
      default:                              sck_out_next = 1'b0;
    endcase
    if (!en_reg)
    begin
      sck_out_next = 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      tmr_half_reg <= 1'b0;
      tmr_prev_reg <= 1'b0;
      sck_out_reg  <= 1'b0;
    end
    else
    begin
      tmr_half_reg <= tmr_half_next;
      tmr_prev_reg <= tmr_s;
      sck_out_reg  <= sck_out_next;
    end
  end

  // Pin roles: nothing is driven while disabled, and 111 drives nothing at all.
  assign o_sck_out      = sck_out_reg;
  assign o_sck_oe       = is_master;
  assign o_sdo_oe       = is_master || (slave_on && slave_sel);
  assign o_twi_active   = en_reg && mode_reg == `MODE_TWI;
  assign o_debounce_sel = o_twi_active ? deb_reg : 2'h0;
  assign o_tw_ctl       = twc_reg;
  assign o_rdata        = rdata_reg;
  assign o_irq          = |(ist_reg & imask_reg);

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);

  sequence s_enable_rise;
    !en_reg ##1 en_reg;
  endsequence

  sequence s_div4_rise;
    en_reg && mode_reg == `MODE_DIV4 && $rose(o_sck_out);
  endsequence

  disabled_pins_quiet_a: assert property (!en_reg |-> !o_sck_oe && !o_sdo_oe)
    else $error("Serial pins driven while disabled.");
  slave_no_clock_a: assert property (mode_reg == `MODE_SLAVE |-> !o_sck_oe)
    else $error("Slave mode drives the serial clock.");
  bit4_reads_zero_a: assert property (i_rd && i_addr == `OFS_CTRL |=> o_rdata[4] == 1'b0)
    else $error("Unimplemented control bit read as one.");
  debounce_spi_off_a: assert property (mode_reg != `MODE_TWI |-> o_debounce_sel == 2'h0)
    else $error("Debounce selection active outside two-wire mode.");
  tw_flags_default_a: assert property (
    s_enable_rise ##0 (mode_reg == `MODE_TWI && !i_wr) |=> twf_reg == `TW_FLAGS_DEF)
    else $error("Two-wire flags not defaulted on enable.");
  spi_ctl_kept_a: assert property (
    s_enable_rise ##0 (mode_reg != `MODE_TWI && !i_wr && evt_reg == '0)
    |=> spi_reg == $past(spi_reg))
    else $error("SPI control changed on enable.");
  tw_ctl_kept_a: assert property (
    s_enable_rise ##0 (mode_reg == `MODE_TWI && !i_wr) |=> twc_reg == $past(twc_reg))
    else $error("Two-wire control bits changed on enable.");
  incomplete_with_trf_a: assert property (
    evt_reg.incomplete |=> icf_reg && spi_reg[`SPI_TRF])
    else $error("Incomplete flag not raised with transfer complete.");
  // Two cycles high then two low pins the period at four, not two or eight.
  div4_period_a: assert property (
    s_div4_rise ##1 (en_reg && !i_wr)[*3]
    |-> !o_sck_out && !$past(o_sck_out) && $past(o_sck_out, 2))
    else $error("Divide-by-four clock period wrong.");
  div4_next_edge_a: assert property (
    s_div4_rise ##1 (en_reg && !i_wr)[*4] |-> $rose(o_sck_out))
    else $error("Divide-by-four clock edge missing.");
endmodule : serial_mode_enable_ctrl

// File: hw/serial_mode_pkg.sv
package serial_mode_pkg;
  typedef logic [7:0] byte_t;
  typedef struct packed {
    logic byte_done;
    logic address_match;
    logic bus_busy;
    logic read_write_request;
    logic received_ack;
  } tw_flags_s;
  typedef struct packed {
    logic done;
    logic incomplete;
  } slave_evt_s;
  typedef enum logic {ST_IDLE, ST_SHIFT} slave_state_e;
endpackage : serial_mode_pkg

// File: hw/sync2.sv
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         i_clock,
  input  wire logic         i_reset_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  // Two stages; only the second stage is visible outside.
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      meta_reg <= '0;
      q_reg    <= '0;
    end
    else
    begin
      meta_reg <= i_d;
      q_reg    <= meta_reg;
    end
  end
  assign o_q = q_reg;
endmodule : sync2
